// [design/parity_report_pkg.sv]
package parity_report_pkg;

  // ==========================================================
  // Transaction type encoding
  localparam logic [1:0] XACT_READ = 2'h0;
  localparam logic [1:0] XACT_POSTED_WR = 2'h1;
  localparam logic [1:0] XACT_DELAYED_WR = 2'h2;

  // ==========================================================
  // Direction and bus encoding
  localparam logic DIR_DOWNSTREAM = 1'h0;
  localparam logic DIR_UPSTREAM = 1'h1;
  localparam logic BUS_UPSTREAM_SIDE = 1'h0;
  localparam logic BUS_DOWNSTREAM_SIDE = 1'h1;

  // ==========================================================
  // Reset values
  localparam logic FLAG_RESET = 1'h0;
  localparam logic PERR_IDLE_N = 1'h1;

  // ==========================================================
  // Error line output enable levels (low while driving)
  localparam logic OE_DRIVE_N = 1'h0;
  localparam logic OE_RELEASE_N = 1'h1;

endpackage

// [design/parity_report.sv]
`timescale 1ns/1ps

// How it works
// R1: Upstream flag only when mastering upstream bus
// R2: Upstream flag needs upstream response enable
// R3: Upstream flag on sampled error line or mismatch
// R4: Downstream flag only when mastering downstream bus
// R5: Downstream flag needs downstream response enable
// R6: Downstream flag on sampled line or mismatch
// R7: Upstream error out for write target/read initiator
// R8: Upstream error out needs upstream response enable
// R9: Upstream out on own error or forwarded delayed-write error
// R10: Downstream error out mirrors upstream rules
// R11: Flags stay set until write-one clear
module parity_report
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Transaction in progress, one-cycle error event
  input wire logic i_err_valid,
  input wire logic [1:0] i_xact_type,
  input wire logic i_direction,
  input wire logic i_err_bus,
  input wire logic i_parity_mismatch,
  // Response enables
  input wire logic i_up_perr_resp_en,
  input wire logic i_dn_perr_resp_en,
  // Parity error lines seen at the pins
  input wire logic i_upstream_side_parity_err_n,
  input wire logic i_downstream_side_parity_err_n,
  // Software write-one clear
  input wire logic i_up_mdpe_clr,
  input wire logic i_dn_mdpe_clr,
  // Status flags
  output logic o_up_mdpe,
  output logic o_dn_mdpe,
  // Driven parity error lines
  output logic o_upstream_side_parity_err_n,
  output logic o_upstream_side_parity_err_oe_n,
  output logic o_downstream_side_parity_err_n,
  output logic o_downstream_side_parity_err_oe_n
);

  // ==========================================================
  // Pin synchronisers
  logic up_line_meta_q;
  logic up_line_sync_q;
  logic dn_line_meta_q;
  logic dn_line_sync_q;
  logic up_line_meta_d;
  logic up_line_sync_d;
  logic dn_line_meta_d;
  logic dn_line_sync_d;

  // Next values of the two-stage synchronisers
  always_comb
  begin
    up_line_meta_d = i_upstream_side_parity_err_n;
    up_line_sync_d = up_line_meta_q;
    dn_line_meta_d = i_downstream_side_parity_err_n;
    dn_line_sync_d = dn_line_meta_q;
  end

  // Synchroniser registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      up_line_meta_q <= parity_report_pkg::PERR_IDLE_N;
      up_line_sync_q <= parity_report_pkg::PERR_IDLE_N;
      dn_line_meta_q <= parity_report_pkg::PERR_IDLE_N;
      dn_line_sync_q <= parity_report_pkg::PERR_IDLE_N;
    end
    else
    begin
      up_line_meta_q <= up_line_meta_d;
      up_line_sync_q <= up_line_sync_d;
      dn_line_meta_q <= dn_line_meta_d;
      dn_line_sync_q <= dn_line_sync_d;
    end
  end

  // ==========================================================
  // Transaction decode
  logic is_read;
  logic is_posted;
  logic is_delayed;
  logic up_err;
  logic dn_err;
  logic master_up;
  logic master_dn;
  logic target_up;
  logic target_dn;
  logic up_seen;
  logic dn_seen;

  // Role of the bridge on each bus and the error bus
  always_comb
  begin
    is_read = (i_xact_type == parity_report_pkg::XACT_READ);
    is_posted = (i_xact_type == parity_report_pkg::XACT_POSTED_WR);
    is_delayed = (i_xact_type == parity_report_pkg::XACT_DELAYED_WR);
    up_err = i_err_valid && (i_err_bus == parity_report_pkg::BUS_UPSTREAM_SIDE);
    dn_err = i_err_valid && (i_err_bus == parity_report_pkg::BUS_DOWNSTREAM_SIDE);
    // Master upstream: upstream read, posted write or delayed write
    master_up = (i_direction == parity_report_pkg::DIR_UPSTREAM)
                && (is_read || is_posted || is_delayed);
    master_dn = (i_direction == parity_report_pkg::DIR_DOWNSTREAM)
                && (is_read || is_posted || is_delayed);
    // Write target or read initiator on the upstream bus
    // Only real write codes count, so the unused type code never asserts a line
    target_up = ((i_direction == parity_report_pkg::DIR_DOWNSTREAM)
                 && (is_posted || is_delayed))
                || ((i_direction == parity_report_pkg::DIR_UPSTREAM) && is_read); // R7
    target_dn = ((i_direction == parity_report_pkg::DIR_UPSTREAM)
                 && (is_posted || is_delayed))
                || ((i_direction == parity_report_pkg::DIR_DOWNSTREAM) && is_read); // R10
    // Error line seen low or own mismatch
    up_seen = !up_line_sync_q || i_parity_mismatch; // R3
    dn_seen = !dn_line_sync_q || i_parity_mismatch; // R6
  end

  // ==========================================================
  // Master data parity flags
  logic up_mdpe_q;
  logic dn_mdpe_q;
  logic up_mdpe_d;
  logic dn_mdpe_d;
  logic up_set;
  logic dn_set;

  // Set wins over the write-one clear
  always_comb
  begin
    up_set = up_err && master_up && i_up_perr_resp_en && up_seen; // R1 R2 R3
    dn_set = dn_err && master_dn && i_dn_perr_resp_en && dn_seen; // R4 R5 R6
    up_mdpe_d = up_set || (up_mdpe_q && !i_up_mdpe_clr); // R11
    dn_mdpe_d = dn_set || (dn_mdpe_q && !i_dn_mdpe_clr); // R11
  end

  // Flag registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      up_mdpe_q <= parity_report_pkg::FLAG_RESET;
      dn_mdpe_q <= parity_report_pkg::FLAG_RESET;
    end
    else
    begin
      up_mdpe_q <= up_mdpe_d;
      dn_mdpe_q <= dn_mdpe_d;
    end
  end

  // ==========================================================
  // Driven parity error lines
  logic up_perr_n_q;
  logic dn_perr_n_q;
  logic up_perr_n_d;
  logic dn_perr_n_d;
  logic up_assert;
  logic dn_assert;
  logic line_oe_n_q;
  logic line_oe_n_d;

  // Assert on own error as target/initiator, or forwarded delayed-write error
  always_comb
  begin
    up_assert = i_up_perr_resp_en // R8
                && ((up_err && target_up && i_parity_mismatch) // R7 R9
                    || (dn_err && is_delayed // R9
                        && (i_direction == parity_report_pkg::DIR_DOWNSTREAM)
                        && !dn_line_sync_q && i_dn_perr_resp_en));
    dn_assert = i_dn_perr_resp_en // R10
                && ((dn_err && target_dn && i_parity_mismatch)
                    || (up_err && is_delayed
                        && (i_direction == parity_report_pkg::DIR_UPSTREAM)
                        && !up_line_sync_q && i_up_perr_resp_en));
    up_perr_n_d = up_assert ? !parity_report_pkg::PERR_IDLE_N : parity_report_pkg::PERR_IDLE_N;
    dn_perr_n_d = dn_assert ? !parity_report_pkg::PERR_IDLE_N : parity_report_pkg::PERR_IDLE_N;
    line_oe_n_d = parity_report_pkg::OE_DRIVE_N;
  end

  // Output line registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      up_perr_n_q <= parity_report_pkg::PERR_IDLE_N;
      dn_perr_n_q <= parity_report_pkg::PERR_IDLE_N;
      line_oe_n_q <= parity_report_pkg::OE_DRIVE_N;
    end
    else
    begin
      up_perr_n_q <= up_perr_n_d;
      dn_perr_n_q <= dn_perr_n_d;
      line_oe_n_q <= line_oe_n_d;
    end
  end

  // Drive lines constantly; idle level is high
  assign o_up_mdpe = up_mdpe_q;
  assign o_dn_mdpe = dn_mdpe_q;
  assign o_upstream_side_parity_err_n = up_perr_n_q;
  assign o_upstream_side_parity_err_oe_n = line_oe_n_q;
  assign o_downstream_side_parity_err_n = dn_perr_n_q;
  assign o_downstream_side_parity_err_oe_n = line_oe_n_q;

  // ==========================================================
  // Checks
  a_up_flag_cause: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(up_mdpe_q) |-> $past(master_up && i_up_perr_resp_en && up_err)) // R1
    else $error("upstream flag set without cause");
  a_up_flag_enable: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (up_err && master_up && !i_up_perr_resp_en && !up_mdpe_q && !i_up_mdpe_clr)
    |=> !up_mdpe_q) // R2
    else $error("upstream flag set while disabled");
  a_up_flag_trigger: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (up_err && master_up && i_up_perr_resp_en && i_parity_mismatch) |=> up_mdpe_q) // R3
    else $error("upstream flag missed");
  a_dn_flag_cause: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(dn_mdpe_q) |-> $past(master_dn && dn_err)) // R4
    else $error("downstream flag set without cause");
  a_dn_flag_enable: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(dn_mdpe_q) |-> $past(i_dn_perr_resp_en)) // R5
    else $error("downstream flag set while disabled");
  a_dn_flag_trigger: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (dn_err && master_dn && i_dn_perr_resp_en && i_parity_mismatch) |=> dn_mdpe_q) // R6
    else $error("downstream flag missed");
  a_up_line_role: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (up_err && target_up && i_parity_mismatch && i_up_perr_resp_en)
    |=> !o_upstream_side_parity_err_n) // R7 R9
    else $error("upstream line not asserted");
  a_up_line_enable: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !o_upstream_side_parity_err_n |-> $past(i_up_perr_resp_en)) // R8
    else $error("upstream line asserted while disabled");
  a_dn_line_enable: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !o_downstream_side_parity_err_n |-> $past(i_dn_perr_resp_en)) // R10
    else $error("downstream line asserted while disabled");
  a_flag_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (up_mdpe_q && !i_up_mdpe_clr) |=> up_mdpe_q) // R11
    else $error("upstream flag dropped");

endmodule

// [tb/perr_agent.sv]
`timescale 1ns/1ps
// ==========================================================
// Far bus agent parity error line, pulled up when released
module perr_agent
(
  // Clock
  input wire logic i_ref_clk,
  // Line level at the pin
  output logic o_line_n
);
  // Idle level from the pull-up
  initial o_line_n = 1'h1;
  // Pulls the line low or lets it go just after a falling edge
  task automatic hold_low(input logic low);
    @(negedge i_ref_clk);
    o_line_n = ~low;
  endtask
endmodule

// [tb/parity_report_tb.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the parity reporting block
module parity_report_tb;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic vld = 1'h0;
  logic [1:0] typ = 2'h0;
  logic dir = 1'h0, bus = 1'h0, mis = 1'h0, ue = 1'h0, de = 1'h0, uc = 1'h0, dc = 1'h0;
  logic up_pin_n, dn_pin_n, uf, df, ul, uoe, dl, doe;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  // Far side agents on both buses
  perr_agent up_agent (.i_ref_clk(clk), .o_line_n(up_pin_n));
  perr_agent dn_agent (.i_ref_clk(clk), .o_line_n(dn_pin_n));

  parity_report dut
  (
    .i_ref_clk(clk), .i_nrst(nrst), .i_err_valid(vld), .i_xact_type(typ),
    .i_direction(dir), .i_err_bus(bus), .i_parity_mismatch(mis),
    .i_up_perr_resp_en(ue), .i_dn_perr_resp_en(de),
    .i_upstream_side_parity_err_n(up_pin_n), .i_downstream_side_parity_err_n(dn_pin_n),
    .i_up_mdpe_clr(uc), .i_dn_mdpe_clr(dc), .o_up_mdpe(uf), .o_dn_mdpe(df),
    .o_upstream_side_parity_err_n(ul), .o_upstream_side_parity_err_oe_n(uoe),
    .o_downstream_side_parity_err_n(dl), .o_downstream_side_parity_err_oe_n(doe)
  );

  // Compares one value
  task automatic check(input string name, input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Prints counts and verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  // One event cycle; returns in the answer cycle
  task automatic ev(input logic [1:0] t, input logic d, input logic b, input logic m,
                    input logic c);
    @(negedge clk);
    vld = 1'h1;
    typ = t;
    dir = d;
    bus = b;
    mis = m;
    uc = c;
    dc = c;
    @(negedge clk);
    vld = 1'h0;
    uc = 1'h0;
    dc = 1'h0;
  endtask

  // Compares flags, lines and enables
  task automatic look(input logic euf, input logic edf, input logic eul, input logic edl);
    check("up flag", uf, euf);
    check("dn flag", df, edf);
    check("up line", ul, eul);
    check("dn line", dl, edl);
    check("line enable", uoe | doe, parity_report_pkg::OE_DRIVE_N);
  endtask

  // Every type, direction, bus and enable pair; d 1 is upstream, b 1 is downstream side
  task automatic t_sweep();
    logic [1:0] t;
    logic d, b, wr;
    for (int i = 0; i < 64; i++)
    begin
      t = i[1:0];
      d = i[2];
      b = i[3];
      ue = i[4];
      de = i[5];
      wr = (t == 2'h1) | (t == 2'h2);
      ev(t, d, b, 1'h1, 1'h0);
      look(ue & d & !b & (t != 2'h3), de & !d & b & (t != 2'h3),
           ~(ue & !b & ((t == 2'h0 & d) | (wr & !d))),
           ~(de & b & ((t == 2'h0 & !d) | (wr & d))));
      ev(2'h3, 1'h0, 1'h0, 1'h0, 1'h1);
      look(1'h0, 1'h0, 1'h1, 1'h1);
    end
    $display("sweep test done");
  endtask

  // Pin-triggered flags and forwarded delayed-write errors
  task automatic t_pins();
    for (int i = 0; i < 4; i++)
    begin
      ue = i[0];
      de = i[1];
      dn_agent.hold_low(1'h1);
      repeat (3) @(negedge clk);
      ev(2'h2, 1'h0, 1'h1, 1'h0, 1'h0);
      look(1'h0, de, ~(ue & de), 1'h1);
      dn_agent.hold_low(1'h0);
      up_agent.hold_low(1'h1);
      repeat (3) @(negedge clk);
      ev(2'h2, 1'h1, 1'h0, 1'h0, 1'h0);
      look(ue, de, 1'h1, ~(ue & de));
      up_agent.hold_low(1'h0);
      repeat (3) @(negedge clk);
      ev(2'h3, 1'h0, 1'h0, 1'h0, 1'h1);
    end
    $display("pin test done");
  endtask

  // Flags hold, clear on write-one, set wins over clear
  task automatic t_sticky();
    ue = 1'h1;
    de = 1'h1;
    ev(2'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    repeat (5) @(negedge clk);
    look(1'h1, 1'h0, 1'h1, 1'h1);
    ev(2'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    look(1'h0, 1'h1, 1'h1, 1'h1);
    ev(2'h3, 1'h0, 1'h0, 1'h0, 1'h1);
    look(1'h0, 1'h0, 1'h1, 1'h1);
    $display("sticky test done");
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk);
    look(1'h0, 1'h0, 1'h1, 1'h1);
    nrst = 1'h1;
    repeat (3) @(negedge clk);
    t_sweep();
    t_pins();
    t_sticky();
    finish_test();
  end
endmodule
